// ===== rtl/pmm_defs.svh
// offsets, field positions, reset values and frame codes of the station controller
`ifndef PMM_DEFS_SVH
`define PMM_DEFS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define PMM_REG_CTRL     8'h00
`define PMM_REG_SID      8'h04
`define PMM_REG_PICONET_IDENTIFIER     8'h08
`define PMM_REG_ATP      8'h0C
`define PMM_REG_REASON   8'h10
`define PMM_REG_STATUS   8'h14
`define PMM_REG_PEER     8'h18
`define PMM_REG_REPEATS  8'h1C
// ------------------------------------------------------------
// control and status fields
// ------------------------------------------------------------
`define PMM_CTRL_JOIN    0
`define PMM_CTRL_LEAVE   1
`define PMM_CTRL_CAPABLE 2
`define PMM_CTRL_OPEN    3
`define PMM_STAT_ASSOC   4
`define PMM_STAT_COORD   5
`define PMM_STAT_FAIL    6
`define PMM_STAT_FETCHED 7
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PMM_RST_ATP      16'h1000
`define PMM_RST_REPEATS  8'h04
// ------------------------------------------------------------
// addresses and frame codes
// ------------------------------------------------------------
`define PMM_ADDR_COORD   8'h00
`define PMM_ADDR_RESP    8'hFE
`define PMM_ADDR_BCAST   8'hFF
`define PMM_ADDR_NONE    8'hFF
`define PMM_FT_ACK       4'h0
`define PMM_FT_ASSOC_REQ 4'h1
`define PMM_FT_ASSOC_RSP 4'h2
`define PMM_FT_DISASSOC  4'h3
`define PMM_FT_CMD_NULL  4'h4
`define PMM_FT_HANDOVER  4'h5
`define PMM_FT_INFO_REQ  4'h6
`define PMM_FT_INFO      4'h7
`define PMM_FT_ANNOUNCE  4'h8
`define PMM_FT_BEACON    4'h9
`define PMM_GRANTED      8'h00
`endif

// ===== rtl/pmm_pkg.sv
// types of the station membership controller
package pmm_pkg;
   typedef enum logic [3:0] {
      PMM_IDLE, PMM_REQ, PMM_WAIT_RESP, PMM_ASSOC, PMM_LEAVE,
      PMM_NOMINATED, PMM_WAIT_BEACON, PMM_COORD
   } pmm_state_e;
endpackage : pmm_pkg

// ===== rtl/pmm_timer.sv
// loadable down counter with expiry flag
`timescale 1ns/1ps
module pmm_timer #(
   parameter int W = 16
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         tick,
   output logic              expired
);
   initial if (W < 2) $error("pmm_timer width too small");
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         run;
      logic         exp;
   } pmm_tmr_s;
   pmm_tmr_s q_ff, nxt_q;
   always_comb begin
      nxt_q = q_ff;
      nxt_q.exp = 1'b0;
      if (load) begin
         nxt_q.cnt = load_val;
         nxt_q.run = 1'b1;
      end else if (q_ff.run && tick) begin
         if (q_ff.cnt == '0) begin
            nxt_q.run = 1'b0;
            nxt_q.exp = 1'b1;
         end else begin
            nxt_q.cnt = q_ff.cnt - 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q_ff <= '0;
      end else if (ce) begin
         q_ff <= nxt_q;
      end
   end
   assign expired = q_ff.exp;
endmodule : pmm_timer

// ===== rtl/pmm_peer_table.sv
// table of short addresses seen in use by peers
`timescale 1ns/1ps
module pmm_peer_table (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       set,
   input  wire logic [7:0] set_addr,
   input  wire logic       clr,
   input  wire logic [7:0] clr_addr,
   input  wire logic [7:0] rd_addr,
   output logic            rd_bit
);
   typedef struct packed {
      logic [255:0] used;
   } pmm_peer_s;
   pmm_peer_s q_ff, nxt_q;
   always_comb begin
      nxt_q = q_ff;
      if (clr) nxt_q.used[clr_addr] = 1'b0;
      if (set) nxt_q.used[set_addr] = 1'b1;
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q_ff <= '0;
      end else if (ce) begin
         q_ff <= nxt_q;
      end
   end
   assign rd_bit = q_ff.used[rd_addr];
endmodule : pmm_peer_table

// ===== rtl/pmm_station.sv
// station side membership controller: join, leave, handover takeover
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "pmm_defs.svh"
module pmm_station #(
   parameter int SID_W = 16
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        cap_active,
   input  wire logic        superframe_start,
   input  wire logic        beacon_slot,
   input  wire logic        rx_valid,
   input  wire logic [3:0]  rx_type,
   input  wire logic [7:0]  rx_dest,
   input  wire logic [7:0]  rx_src,
   input  wire logic [15:0] rx_piconet_identifier,
   input  wire logic [SID_W-1:0] rx_sid,
   input  wire logic [7:0]  rx_addr,
   input  wire logic [15:0] rx_arg,
   input  wire logic        tx_done,
   output logic             tx_req,
   output logic      [3:0]  tx_type,
   output logic      [7:0]  tx_dest,
   output logic      [7:0]  tx_src,
   output logic      [15:0] tx_piconet_identifier,
   output logic [SID_W-1:0] tx_sid,
   output logic      [15:0] tx_arg,
   output logic             tx_flag,
   output logic             ack_send,
   output logic      [7:0]  ack_dest
);
   initial if (SID_W < 1 || SID_W > 16) $error("pmm_station SID_W out of range");
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      pmm_pkg::pmm_state_e st;
      logic              capable;
      logic              open_reg;
      logic [SID_W-1:0]  sid;
      logic [15:0]       piconet_identifier;
      logic [15:0]       association_timeout_period;
      logic [7:0]        reason;
      logic [7:0]        repeats;
      logic [7:0]        my_addr;
      logic              assoc;
      logic              coord;
      logic              fail;
      logic              fetched;
      logic [7:0]        ann_cnt;
      logic [7:0]        peer_idx;
      logic [31:0]       rdata;
      logic              pend;
      logic              cap_only;
      logic              tx_req;
      logic [3:0]        tx_type;
      logic [7:0]        tx_dest;
      logic [7:0]        tx_src;
      logic [15:0]       tx_piconet_identifier;
      logic [15:0]       tx_arg;
      logic              ack_send;
      logic [7:0]        ack_dest;
   } pmm_st_s;
   pmm_st_s q_ff, nxt_q;
   logic rsp_exp, ho_exp, peer_bit, rsp_load, ho_load, peer_set, peer_clr;
   logic rx_mine, grant;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   pmm_timer #(.W(16)) u_rsp_tmr (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .load(rsp_load),
      .load_val(q_ff.association_timeout_period), .tick(1'b1), .expired(rsp_exp));
   pmm_timer #(.W(16)) u_ho_tmr (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .load(ho_load),
      .load_val(rx_arg), .tick(superframe_start), .expired(ho_exp));
   pmm_peer_table u_peers (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .set(peer_set), .set_addr(rx_addr),
      .clr(peer_clr), .clr_addr(rx_dest), .rd_addr(q_ff.peer_idx), .rd_bit(peer_bit));
   assign rx_mine = rx_valid && q_ff.assoc && (rx_dest == q_ff.my_addr ||
                    (q_ff.coord && rx_dest == `PMM_ADDR_COORD));
   assign grant = rx_arg[7:0] == `PMM_GRANTED && rx_addr != `PMM_ADDR_COORD && rx_addr != `PMM_ADDR_NONE;
   // grants seen on the broadcast response update the peer table
   assign peer_set = rx_valid && rx_type == `PMM_FT_ASSOC_RSP && rx_dest == `PMM_ADDR_RESP && grant;
   assign peer_clr = rx_valid && rx_type == `PMM_FT_DISASSOC;
   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_q = q_ff;
      nxt_q.rdata = '0;
      nxt_q.ack_send = 1'b0;
      rsp_load = 1'b0;
      ho_load = 1'b0;
      if (tx_done) nxt_q.pend = 1'b0;
      if (reg_wr) begin
         unique case (reg_addr)
            `PMM_REG_CTRL: begin
               nxt_q.capable = reg_wdata[`PMM_CTRL_CAPABLE];
               nxt_q.open_reg = reg_wdata[`PMM_CTRL_OPEN];
            end
            `PMM_REG_SID: nxt_q.sid = reg_wdata[SID_W-1:0];
            `PMM_REG_PICONET_IDENTIFIER: nxt_q.piconet_identifier = reg_wdata[15:0];
            `PMM_REG_ATP: nxt_q.association_timeout_period = reg_wdata[15:0];
            `PMM_REG_REASON: nxt_q.reason = reg_wdata[7:0];
            `PMM_REG_STATUS: if (reg_wdata[`PMM_STAT_FAIL]) nxt_q.fail = 1'b0;
            `PMM_REG_PEER: nxt_q.peer_idx = reg_wdata[7:0];
            `PMM_REG_REPEATS: nxt_q.repeats = reg_wdata[7:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `PMM_REG_CTRL: nxt_q.rdata = 32'({q_ff.open_reg, q_ff.capable, 2'b00});
            `PMM_REG_SID: nxt_q.rdata = 32'(q_ff.sid);
            `PMM_REG_PICONET_IDENTIFIER: nxt_q.rdata = 32'(q_ff.piconet_identifier);
            `PMM_REG_ATP: nxt_q.rdata = 32'(q_ff.association_timeout_period);
            `PMM_REG_REASON: nxt_q.rdata = 32'(q_ff.reason);
            `PMM_REG_STATUS: nxt_q.rdata = 32'({q_ff.my_addr, q_ff.fetched, q_ff.fail, q_ff.coord,
                                               q_ff.assoc, q_ff.st});
            `PMM_REG_PEER: nxt_q.rdata = 32'({peer_bit, q_ff.peer_idx});
            `PMM_REG_REPEATS: nxt_q.rdata = 32'(q_ff.repeats);
            default: nxt_q.rdata = '0;
         endcase
      end
      unique case (q_ff.st)
         pmm_pkg::PMM_IDLE: begin
            if (reg_wr && reg_addr == `PMM_REG_CTRL && reg_wdata[`PMM_CTRL_JOIN]) begin
               nxt_q.st = pmm_pkg::PMM_REQ;
               nxt_q.pend = 1'b1;
               nxt_q.cap_only = 1'b1;
               nxt_q.tx_type = `PMM_FT_ASSOC_REQ;
               nxt_q.tx_dest = `PMM_ADDR_COORD;
               nxt_q.tx_src = `PMM_ADDR_NONE;
               nxt_q.tx_piconet_identifier = nxt_q.open_reg ? 16'h0000 : nxt_q.piconet_identifier;
               nxt_q.tx_arg = nxt_q.association_timeout_period;
               rsp_load = 1'b1;
            end
         end
         pmm_pkg::PMM_REQ: begin
            if (rx_valid && rx_type == `PMM_FT_ACK && rx_dest == `PMM_ADDR_NONE && !nxt_q.pend) begin
               nxt_q.st = pmm_pkg::PMM_WAIT_RESP;
               rsp_load = 1'b1;
            end else if (rsp_exp) begin
               nxt_q.st = pmm_pkg::PMM_IDLE;
               nxt_q.pend = 1'b0;
               nxt_q.fail = 1'b1;
            end
         end
         pmm_pkg::PMM_WAIT_RESP: begin
            // broadcast response: matched on identifier, never acknowledged
            if (rx_valid && rx_type == `PMM_FT_ASSOC_RSP && rx_dest == `PMM_ADDR_RESP
                && rx_sid == q_ff.sid && (q_ff.open_reg || rx_piconet_identifier == q_ff.piconet_identifier)) begin
               if (grant) begin
                  nxt_q.st = pmm_pkg::PMM_ASSOC;
                  nxt_q.assoc = 1'b1;
                  nxt_q.my_addr = rx_addr;
                  if (q_ff.open_reg) nxt_q.piconet_identifier = rx_piconet_identifier;
               end else begin
                  nxt_q.st = pmm_pkg::PMM_IDLE;
                  nxt_q.fail = 1'b1;
               end
            end else if (rsp_exp) begin
               nxt_q.st = pmm_pkg::PMM_IDLE;
               nxt_q.fail = 1'b1;
            end
         end
         pmm_pkg::PMM_ASSOC, pmm_pkg::PMM_COORD: begin
            if (rx_mine && rx_type == `PMM_FT_DISASSOC && !q_ff.coord) begin
               nxt_q.ack_send = 1'b1;
               nxt_q.ack_dest = rx_src;
               nxt_q.st = pmm_pkg::PMM_IDLE;
               nxt_q.assoc = 1'b0;
               nxt_q.my_addr = `PMM_ADDR_NONE;
               nxt_q.pend = 1'b0;
            end else if (rx_mine && rx_type != `PMM_FT_ACK && rx_type != `PMM_FT_ASSOC_RSP) begin
               nxt_q.ack_send = 1'b1;
               nxt_q.ack_dest = rx_src;
               if (rx_type == `PMM_FT_HANDOVER && q_ff.capable && !q_ff.coord) begin
                  nxt_q.st = pmm_pkg::PMM_NOMINATED;
                  nxt_q.fetched = 1'b0;
                  nxt_q.ann_cnt = '0;
                  ho_load = 1'b1;
                  nxt_q.pend = 1'b1;
                  nxt_q.cap_only = 1'b0;
                  nxt_q.tx_type = `PMM_FT_INFO_REQ;
                  nxt_q.tx_dest = `PMM_ADDR_COORD;
                  nxt_q.tx_src = q_ff.my_addr;
                  nxt_q.tx_piconet_identifier = q_ff.piconet_identifier;
                  nxt_q.tx_arg = '0;
               end
            end else if (reg_wr && reg_addr == `PMM_REG_CTRL && reg_wdata[`PMM_CTRL_LEAVE]
                         && !q_ff.coord && !q_ff.pend) begin
               nxt_q.st = pmm_pkg::PMM_LEAVE;
               nxt_q.pend = 1'b1;
               nxt_q.cap_only = 1'b0;
               nxt_q.tx_type = `PMM_FT_DISASSOC;
               nxt_q.tx_dest = `PMM_ADDR_COORD;
               nxt_q.tx_src = q_ff.my_addr;
               nxt_q.tx_piconet_identifier = q_ff.piconet_identifier;
               nxt_q.tx_arg = 16'(q_ff.reason);
            end
         end
         pmm_pkg::PMM_LEAVE: begin
            if (rx_valid && rx_type == `PMM_FT_ACK && rx_dest == q_ff.my_addr && !nxt_q.pend) begin
               nxt_q.st = pmm_pkg::PMM_IDLE;
               nxt_q.assoc = 1'b0;
               nxt_q.my_addr = `PMM_ADDR_NONE;
            end
         end
         pmm_pkg::PMM_NOMINATED: begin
            if (rx_mine && rx_type == `PMM_FT_INFO) begin
               nxt_q.fetched = 1'b1;
               nxt_q.ack_send = 1'b1;
               nxt_q.ack_dest = rx_src;
            end
            if (ho_exp) begin
               nxt_q.st = pmm_pkg::PMM_WAIT_BEACON;
            end else if (superframe_start && q_ff.ann_cnt < q_ff.repeats && !nxt_q.pend) begin
               nxt_q.ann_cnt = q_ff.ann_cnt + 8'h01;
               nxt_q.pend = 1'b1;
               nxt_q.tx_type = `PMM_FT_ANNOUNCE;
               nxt_q.tx_dest = `PMM_ADDR_BCAST;
               nxt_q.tx_src = q_ff.my_addr;
            end
         end
         pmm_pkg::PMM_WAIT_BEACON: begin
            if (beacon_slot) begin
               nxt_q.st = pmm_pkg::PMM_COORD;
               nxt_q.coord = 1'b1;
               nxt_q.pend = 1'b1;
               nxt_q.tx_type = `PMM_FT_BEACON;
               nxt_q.tx_dest = `PMM_ADDR_BCAST;
               nxt_q.tx_src = `PMM_ADDR_COORD;
            end
         end
         default: nxt_q.st = pmm_pkg::PMM_IDLE;
      endcase
      nxt_q.tx_req = nxt_q.pend && (!nxt_q.cap_only || cap_active);
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q_ff <= '0;
         q_ff.st <= pmm_pkg::PMM_IDLE;
         q_ff.association_timeout_period <= `PMM_RST_ATP;
         q_ff.repeats <= `PMM_RST_REPEATS;
         q_ff.my_addr <= `PMM_ADDR_NONE;
      end else if (ce) begin
         q_ff <= nxt_q;
      end
   end
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rdata = q_ff.rdata;
   assign tx_req = q_ff.tx_req;
   assign tx_type = q_ff.tx_type;
   assign tx_dest = q_ff.tx_dest;
   assign tx_src = q_ff.tx_src;
   assign tx_piconet_identifier = q_ff.tx_piconet_identifier;
   assign tx_sid = q_ff.sid;
   assign tx_arg = q_ff.tx_arg;
   assign tx_flag = q_ff.capable;
   assign ack_send = q_ff.ack_send;
   assign ack_dest = q_ff.ack_dest;
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   cap_only_a: assert property (tx_req && tx_type == `PMM_FT_ASSOC_REQ |-> $past(cap_active) || !$past(ce))
      else $error("association request outside contention period");
   join_dest_a: assert property (tx_req && tx_type == `PMM_FT_ASSOC_REQ |-> tx_dest == `PMM_ADDR_COORD && !q_ff.assoc)
      else $error("association request misdirected");
   resp_noack_a: assert property (ce && rx_valid && rx_type == `PMM_FT_ASSOC_RSP |=> !ack_send)
      else $error("association response acknowledged");
   adopt_addr_a: assert property (ce && q_ff.st == pmm_pkg::PMM_WAIT_RESP && rx_valid
      && rx_type == `PMM_FT_ASSOC_RSP && rx_dest == `PMM_ADDR_RESP && rx_sid == q_ff.sid && grant
      && (q_ff.open_reg || rx_piconet_identifier == q_ff.piconet_identifier) |=> q_ff.assoc && q_ff.my_addr == $past(rx_addr))
      else $error("granted address not adopted");
   disassoc_ack_a: assert property (ce && rx_mine && rx_type == `PMM_FT_DISASSOC && !q_ff.coord
      |=> ack_send && ack_dest == $past(rx_src) ##1 !q_ff.assoc || !$past(ce))
      else $error("disassociation not acknowledged");
   open_piconet_identifier_a: assert property (tx_req && tx_type == `PMM_FT_ASSOC_REQ && q_ff.open_reg |-> tx_piconet_identifier == 16'h0000)
      else $error("open request carries network identifier");
   leave_reason_a: assert property (tx_req && tx_type == `PMM_FT_DISASSOC
      |-> tx_dest == `PMM_ADDR_COORD && tx_arg == 16'(q_ff.reason))
      else $error("disassociation lacks reason");
   capable_flag_a: assert property ($rose(q_ff.st == pmm_pkg::PMM_NOMINATED) |-> $past(q_ff.capable))
      else $error("nomination taken while not capable");
   first_beacon_a: assert property (ce && q_ff.st == pmm_pkg::PMM_WAIT_BEACON && beacon_slot
      |=> tx_type == `PMM_FT_BEACON && tx_src == `PMM_ADDR_COORD && q_ff.coord)
      else $error("first beacon missed");
   coord_addr_a: assert property (q_ff.coord |-> q_ff.assoc && q_ff.my_addr != `PMM_ADDR_COORD)
      else $error("coordinator lost ordinary address");
   ann_limit_a: assert property (q_ff.st == pmm_pkg::PMM_NOMINATED |-> q_ff.ann_cnt <= q_ff.repeats)
      else $error("announce count overrun");
   assoc_c: cover property (q_ff.st == pmm_pkg::PMM_WAIT_RESP ##1 q_ff.st == pmm_pkg::PMM_ASSOC);
   leave_c: cover property (q_ff.st == pmm_pkg::PMM_LEAVE ##1 q_ff.st == pmm_pkg::PMM_IDLE);
   coord_c: cover property (q_ff.st == pmm_pkg::PMM_WAIT_BEACON ##1 q_ff.st == pmm_pkg::PMM_COORD);
endmodule : pmm_station

// ===== test/pmm_coord_model.sv
// behavioural coordinator answering the station's frames
`timescale 1ns/1ps
`include "pmm_defs.svh"
module pmm_coord_model #(
   parameter int          SID_W = 16,
   parameter logic [15:0] PICONET_IDENTIFIER  = 16'h5A3C,
   parameter int          RETRY = 3
) (
   input  wire logic             core_clk,
   input  wire logic             tx_req,
   input  wire logic [3:0]       tx_type,
   input  wire logic [7:0]       tx_src,
   input  wire logic [15:0]      tx_piconet_identifier,
   input  wire logic [SID_W-1:0] tx_sid,
   input  wire logic             ack_send,
   input  wire logic [7:0]       ack_dest,
   input  wire logic             refuse,
   input  wire logic             slow,
   output logic                  rx_valid,
   output logic      [3:0]       rx_type,
   output logic      [7:0]       rx_dest,
   output logic      [7:0]       rx_src,
   output logic      [15:0]      rx_piconet_identifier,
   output logic      [SID_W-1:0] rx_sid,
   output logic      [7:0]       rx_addr,
   output logic      [15:0]      rx_arg,
   output logic                  tx_done
);
   // ------------------------------------------------------------
   // frame exchange
   // ------------------------------------------------------------
   logic [7:0]       next_addr;
   logic [3:0]       ft;
   logic [7:0]       src;
   logic [15:0]      pn;
   logic [SID_W-1:0] sid;
   logic             got;
   logic             grant;
   assign rx_src  = `PMM_ADDR_COORD;
   assign rx_piconet_identifier = PICONET_IDENTIFIER;
   task automatic send(input logic [3:0] t, input logic [7:0] d, input logic [7:0] a, input logic [15:0] g,
                       input logic [SID_W-1:0] s);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      {rx_type, rx_dest, rx_addr, rx_arg, rx_sid} <= {t, d, a, g, s};
      @(posedge core_clk);
      rx_valid <= 1'b0;
      {rx_type, rx_dest, rx_addr, rx_arg, rx_sid} <= ~{t, d, a, g, s};
   endtask : send
   initial begin
      rx_valid = 1'b0;
      {rx_type, rx_dest, rx_addr, rx_arg, rx_sid} = '0;
      tx_done = 1'b0;
      next_addr = 8'h01;
      forever begin
         @(posedge core_clk);
         if (tx_req === 1'b1) begin
            {ft, src, pn, sid} = {tx_type, tx_src, tx_piconet_identifier, tx_sid};
            repeat (slow ? 6 : 1) @(posedge core_clk);
            tx_done <= 1'b1;
            @(posedge core_clk);
            tx_done <= 1'b0;
            if (ft == `PMM_FT_ASSOC_REQ) begin
               send(`PMM_FT_ACK, `PMM_ADDR_NONE, 8'h00, 16'h0000, '0);
               grant = !(refuse && pn == 16'h0000);
               got = 1'b0;
               for (int i = 0; i < RETRY && !got; i++) begin
                  send(`PMM_FT_ASSOC_RSP, `PMM_ADDR_RESP, next_addr, grant ? 16'h0000 : 16'h0001, sid);
                  got = !grant;
                  if (grant) send(`PMM_FT_CMD_NULL, next_addr, 8'h00, 16'h0000, '0);
                  repeat (4) begin
                     @(posedge core_clk);
                     if (grant && ack_send === 1'b1 && ack_dest === `PMM_ADDR_COORD) got = 1'b1;
                  end
               end
               if (grant && got) next_addr = next_addr + 8'h01;
               send(`PMM_FT_INFO, `PMM_ADDR_BCAST, 8'h00, 16'h0000, '0);
            end
            else if (ft == `PMM_FT_DISASSOC) send(`PMM_FT_ACK, src, 8'h00, 16'h0000, '0);
            else if (ft == `PMM_FT_INFO_REQ) send(`PMM_FT_INFO, src, 8'h00, 16'h0000, '0);
         end
      end
   end
endmodule : pmm_coord_model

// ===== test/pmm_station_tb.sv
// self-checking bench of the station membership controller
`timescale 1ns/1ps
`include "pmm_defs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("unexpected at %0t: got %0h want %0h", $time, a, e); end end
module pmm_station_tb;
   // ------------------------------------------------------------
   // signals, design and partner
   // ------------------------------------------------------------
   typedef struct {logic [7:0] a; logic [31:0] e;} pmm_row_s;
   localparam logic [15:0] PICONET_IDENTIFIER_V = 16'h5A3C;
   logic        core_clk, rst_n, reg_wr, reg_rd, cap_active, superframe_start, beacon_slot, rx_valid;
   logic        tx_done, tx_req, tx_flag, ack_send, refuse, slow;
   logic [7:0]  reg_addr, rx_dest, rx_src, rx_addr, tx_dest, tx_src, ack_dest;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [3:0]  rx_type, tx_type;
   logic [15:0] rx_piconet_identifier, rx_arg, tx_piconet_identifier, tx_arg, rx_sid, tx_sid;
   logic [7:0]  sd [16];
   logic [7:0]  ss [16];
   logic [15:0] sa [16];
   int          fail_count = 0, total_checks = 0, nann = 0;
   pmm_row_s    rows [6] = '{'{`PMM_REG_CTRL, 32'h0}, '{`PMM_REG_STATUS, 32'hFF00}, '{`PMM_REG_ATP, 32'h1000},
                             '{`PMM_REG_REPEATS, 32'h4}, '{`PMM_REG_REASON, 32'h0}, '{8'h20, 32'h0}};
   pmm_station pmm_station_inst (.core_clk, .rst_n, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .cap_active, .superframe_start, .beacon_slot, .rx_valid, .rx_type, .rx_dest, .rx_src,
      .rx_piconet_identifier, .rx_sid, .rx_addr, .rx_arg, .tx_done, .tx_req, .tx_type, .tx_dest, .tx_src, .tx_piconet_identifier,
      .tx_sid, .tx_arg, .tx_flag, .ack_send, .ack_dest);
   pmm_coord_model #(.PICONET_IDENTIFIER(PICONET_IDENTIFIER_V)) pmm_coord_model_inst (.core_clk, .tx_req, .tx_type, .tx_src, .tx_piconet_identifier,
      .tx_sid, .ack_send, .ack_dest, .refuse, .slow, .rx_valid, .rx_type, .rx_dest, .rx_src, .rx_piconet_identifier,
      .rx_sid, .rx_addr, .rx_arg, .tx_done);
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (tx_done === 1'b1 && tx_req === 1'b1) begin
         sd[tx_type] <= tx_dest;
         ss[tx_type] <= tx_src;
         sa[tx_type] <= tx_arg;
         if (tx_type == `PMM_FT_ANNOUNCE) nann <= nann + 1;
      end
   end
   // ------------------------------------------------------------
   // register access and checks
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      for (int i = 0; i < 400; i++) begin
         rd(a);
         if ((d & m) === v) break;
      end
      `CHK(d & m, v)
   endtask : poll
   task automatic rx(input logic [3:0] t, input logic [7:0] a, input logic [15:0] g);
      repeat (10) @(posedge core_clk);
      pmm_coord_model_inst.send(t, a, 8'h00, g, '0);
      #1 `CHK({ack_send, ack_dest}, 9'h100)
   endtask : rx
   task automatic leave();
      wr(`PMM_REG_CTRL, 32'h6);
      poll(`PMM_REG_STATUS, 32'h1F, 32'h0);
      `CHK(sd[3], 8'h00)
      `CHK(sa[3], 16'h002A)
   endtask : leave
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (30000) @(posedge core_clk);
      fail_count++;
      finish_test();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, cap_active, superframe_start, beacon_slot, refuse, slow} = '0;
      {reg_addr, reg_wdata} = '0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) poll(rows[i].a, 32'hFFFF_FFFF, rows[i].e);
      wr(`PMM_REG_SID, 32'h1234);
      wr(`PMM_REG_PICONET_IDENTIFIER, {16'h0, PICONET_IDENTIFIER_V});
      wr(`PMM_REG_ATP, 32'h28);
      wr(`PMM_REG_REASON, 32'h2A);
      wr(`PMM_REG_CTRL, 32'h5);
      repeat (3) @(posedge core_clk);
      `CHK(tx_req, 1'b0)
      `CHK(tx_flag, 1'b1)
      cap_active <= 1'b1;
      poll(`PMM_REG_STATUS, 32'hFF10, 32'h0110);
      `CHK(sd[1], 8'h00)
      `CHK(sa[1], 16'h0028)
      wr(`PMM_REG_PEER, 32'h1);
      poll(`PMM_REG_PEER, 32'h1FF, 32'h101);
      leave();
      slow <= 1'b1;
      wr(`PMM_REG_CTRL, 32'h5);
      poll(`PMM_REG_STATUS, 32'hFF10, 32'h0210);
      rx(`PMM_FT_DISASSOC, 8'h02, 16'h0001);
      poll(`PMM_REG_STATUS, 32'hFF1F, 32'hFF00);
      wr(`PMM_REG_CTRL, 32'h5);
      poll(`PMM_REG_STATUS, 32'hFF10, 32'h0310);
      leave();
      refuse <= 1'b1;
      wr(`PMM_REG_PICONET_IDENTIFIER, 32'h0);
      wr(`PMM_REG_CTRL, 32'hD);
      poll(`PMM_REG_STATUS, 32'h50, 32'h40);
      wr(`PMM_REG_STATUS, 32'h40);
      poll(`PMM_REG_STATUS, 32'h40, 32'h0);
      {refuse, slow} <= 2'b00;
      wr(`PMM_REG_CTRL, 32'hD);
      poll(`PMM_REG_STATUS, 32'hFF10, 32'h0410);
      rx(`PMM_FT_HANDOVER, 8'h04, 16'h0005);
      repeat (6) begin
         repeat (20) @(posedge core_clk);
         superframe_start <= 1'b1;
         @(posedge core_clk);
         superframe_start <= 1'b0;
      end
      repeat (2) @(posedge core_clk);
      beacon_slot <= 1'b1;
      @(posedge core_clk);
      beacon_slot <= 1'b0;
      poll(`PMM_REG_STATUS, 32'hFFA0, 32'h04A0);
      for (int i = 0; i < 50 && ss[9] !== 8'h00; i++) @(posedge core_clk);
      `CHK(ss[9], 8'h00)
      `CHK(nann >= 4, 1'b1)
      finish_test();
   end
endmodule : pmm_station_tb
